// [rtl/ghp_pkg.sv]
// package: constants and types for the generic host bus port
package ghp_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 18;                 // byte address width
  localparam int DATA_W = 16;                 // data lines width
  localparam int MEM_WORD_W = 18;             // word index, two spaces
  localparam int SPACE_WORD_W = 17;           // 256K bytes = 128K words
  localparam int DEPTH = 262144;              // words in both spaces
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;           // clock period in ns
  localparam int MIN_XFER_NS = 8;             // two bus clocks at least
  localparam int MIN_XFER_CYC =
    (MIN_XFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] ACK_DELAY = 2'h1;    // extra wait before ack
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // port states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    GHP_IDLE,
    GHP_ARB,
    GHP_ACK,
    GHP_DONE
  } ghp_state_e;
endpackage : ghp_pkg

// [rtl/ghp_mem.sv]
// single-port word memory with byte lanes and registered read data
`timescale 1ns/1ps
module ghp_mem
  import ghp_pkg::*;
(
  // clock
  input wire logic clk,
  // access
  input wire logic [MEM_WORD_W-1:0] addr,
  input wire logic [1:0] wrLane,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic rdEn,
  output logic [DATA_W-1:0] rdData
);
  // ---------------------------------------------------------------
  // one bank per byte lane, so each lane has a single writer
  // ---------------------------------------------------------------
  for (genvar lane = 0; lane < 2; lane++) begin : gLane
    logic [7:0] bank [DEPTH]; // this lane's byte of every word
    always_ff @(posedge clk) begin
      if (wrLane[lane]) begin
        bank[addr] <= wrData[lane*8 +: 8];
      end
    end
    // read data from a register, no reset so it maps onto a ram
    always_ff @(posedge clk) begin
      if (rdEn) begin
        rdData[lane*8 +: 8] <= bank[addr];
      end
    end
  end
endmodule : ghp_mem

// [rtl/ghp_port.sv]
// generic mode one host bus slave port with refresh arbitration
`timescale 1ns/1ps
module ghp_port
  import ghp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // mode straps
  input wire logic endian_strap,
  input wire logic hold_polarity_strap,
  input wire logic clock_divide_strap,
  // host bus
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic space_select,
  input wire logic device_select_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic low_byte_read_n,
  input wire logic high_byte_read_n,
  input wire logic bus_status_n,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  output logic hold_off_n,
  // display refresh side
  input wire logic refresh_busy,
  // mode status
  output logic bigEndian,
  output logic busClockHalf
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta_reg;  // first stage, read only by second
  logic rstSync_reg;  // released reset for the rest of the port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ---------------------------------------------------------------
  // strap latch
  // ---------------------------------------------------------------
  logic strapDone_reg, strapDone_next;  // straps already caught
  logic endian_reg, endian_next;        // big endian byte order
  logic polHigh_reg, polHigh_next;      // hold off active high
  logic divide_reg, divide_next;        // bus clock is half rate
  logic phase_reg, phase_next;          // divided bus clock phase
  logic busTick;                        // one internal bus clock

  // straps caught once in the first cycle after release
  always_comb begin
    strapDone_next = 1'b1;
    endian_next = endian_reg;
    polHigh_next = polHigh_reg;
    divide_next = divide_reg;
    if (!strapDone_reg) begin
      endian_next = endian_strap;
      polHigh_next = hold_polarity_strap;
      divide_next = clock_divide_strap;
    end
    // bus_status_n has no function in this mode
    phase_next = divide_reg ? ~phase_reg : 1'b0;
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      strapDone_reg <= 1'b0;
      endian_reg <= 1'b0;
      polHigh_reg <= 1'b0;
      divide_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else begin
      strapDone_reg <= strapDone_next;
      endian_reg <= endian_next;
      polHigh_reg <= polHigh_next;
      divide_reg <= divide_next;
      phase_reg <= phase_next;
    end
  end

  // with the 2:1 ratio the sequencer case steps only on every other clock
  assign busTick = !divide_reg || phase_reg;

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  ghp_state_e state_reg, state_next;
  logic [1:0] wait_reg, wait_next;        // cycles spent before ack
  logic waitAsserted;                     // logical hold-off level
  logic holdPin_reg, holdPin_next;        // hold_off_n pin level
  logic oe_reg, oe_next;                  // data lines driven
  logic [DATA_W-1:0] dout_reg, dout_next; // read data on pins
  logic [MEM_WORD_W-1:0] memAddr;         // word index into memory
  logic [1:0] wrLane;                     // lane write strobes
  logic [DATA_W-1:0] wrData;              // lane-ordered write data
  logic [DATA_W-1:0] rdData;              // memory read data
  logic rdEn;                             // memory read request
  logic reading;                          // any read enable low
  logic writing;                          // any write strobe low
  logic sel;                              // selected and ready

  // the space bit sits above the 256K offset, byte address bit 0 is dropped
  assign memAddr = {space_select, addr_in[ADDR_W-1:1]};
  assign reading = !low_byte_read_n || !high_byte_read_n;
  assign writing = !low_byte_write_n || !high_byte_write_n;
  assign sel = !device_select_n && strapDone_reg;

  // big endian swaps the host's byte pair onto the lanes
  assign wrData = endian_reg ? {data_lines_in[7:0], data_lines_in[15:8]}
                             : data_lines_in;

  // lanes are written at the tick that wins arbitration, while the
  // host still holds its data under the wait
  assign wrLane = (state_reg == GHP_ARB && busTick && !refresh_busy
                   && wait_reg >= ACK_DELAY && sel)
                  ? {~high_byte_write_n, ~low_byte_write_n}
                  : 2'h0;
  assign rdEn = state_reg == GHP_ARB && busTick && !refresh_busy;

  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    waitAsserted = 1'b0;
    dout_next = dout_reg;
    oe_next = sel && reading;
    if (busTick) begin
      unique case (state_reg)
        // idle until selected with a strobe present
        GHP_IDLE: begin
          if (sel && (reading || writing)) begin
            state_next = GHP_ARB;
            wait_next = 2'h0;
          end
        end
        // stall while refresh owns the memory
        GHP_ARB: begin
          if (!refresh_busy && wait_reg >= ACK_DELAY) begin
            state_next = GHP_ACK;
          end else if (wait_reg < ACK_DELAY) begin
            wait_next = wait_reg + 2'h1;
          end
          if (!sel) begin
            state_next = GHP_IDLE;  // host gave up the cycle
          end
        end
        // ack for one bus clock, read data now valid
        GHP_ACK: begin
          state_next = GHP_DONE;
        end
        // wait for select or strobe release before a new access
        GHP_DONE: begin
          if (!sel || !(reading || writing)) begin
            state_next = GHP_IDLE;
          end
        end
      endcase
    end
    // released strobes end the access on any clock, so at half rate
    // a single idle clock between accesses is not missed
    if ((state_reg == GHP_ACK || state_reg == GHP_DONE)
        && !(sel && (reading || writing))) begin
      state_next = GHP_IDLE;
    end
    if (state_reg == GHP_ACK) begin
      dout_next = endian_reg ? {rdData[7:0], rdData[15:8]} : rdData;
    end
    // the pin stays in hold until data is valid or taken
    waitAsserted = (state_next == GHP_ARB) || (state_next == GHP_IDLE
                   && sel && (reading || writing));
    holdPin_next = polHigh_reg ? waitAsserted : ~waitAsserted;
  end

  always_ff @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= GHP_IDLE;
      wait_reg <= 2'h0;
      holdPin_reg <= 1'b1;
      oe_reg <= 1'b0;
      dout_reg <= DATA_RESET;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      holdPin_reg <= holdPin_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
    end
  end

  // ---------------------------------------------------------------
  // storage for registers and display buffer
  // ---------------------------------------------------------------
  ghp_mem uMem (
    .clk(clk),
    .addr(memAddr),
    .wrLane(wrLane),
    .wrData(wrData),
    .rdEn(rdEn),
    .rdData(rdData)
  );

  // ---------------------------------------------------------------
  // outputs, each from a flip-flop
  // ---------------------------------------------------------------
  assign data_lines_out = dout_reg;
  assign data_lines_oe = oe_reg;
  assign hold_off_n = holdPin_reg;
  assign bigEndian = endian_reg;
  assign busClockHalf = divide_reg;
endmodule : ghp_port

// [verification/ghp_port_chk.sv]
// checker: timing properties seen at the host port pins
`timescale 1ns/1ps
module ghp_port_chk
  import ghp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // straps, host strobes and refresh
  input wire logic hold_polarity_strap,
  input wire logic clock_divide_strap,
  input wire logic device_select_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic low_byte_read_n,
  input wire logic high_byte_read_n,
  input wire logic refresh_busy,
  // port outputs
  input wire logic data_lines_oe,
  input wire logic hold_off_n,
  input wire logic bigEndian,
  input wire logic busClockHalf
);
  // --------
  // arming
  // --------
  logic [2:0] upCnt_reg; // cycles since release, saturating
  logic [2:0] upCnt_next;
  logic live; // straps latched, outputs meaningful
  logic wt; // port holds the host off
  logic rdReq; // read strobe under select
  logic req; // any strobe under select
  // wait for the strap latch so idle levels are not misread
  always_comb begin
    upCnt_next = live ? upCnt_reg : upCnt_reg + 3'h1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) upCnt_reg <= 3'h0;
    else upCnt_reg <= upCnt_next;
  end
  assign live = (upCnt_reg == 3'h7);
  assign wt = live && (hold_off_n == hold_polarity_strap);
  assign rdReq = !device_select_n && !(low_byte_read_n && high_byte_read_n);
  assign req = rdReq || (!device_select_n &&
    !(low_byte_write_n && high_byte_write_n));
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // --------
  // properties
  // --------
  a_min_wait: assert property (
    live && $rose(req) |=> wt [*2]) else $error("wait under two ticks");
  a_no_rewait: assert property (
    live && !wt && !$rose(req) |=> !wt) else $error("wait without take");
  a_refresh_hold: assert property (
    wt && refresh_busy |=> wt) else $error("wait ended in refresh");
  a_wait_bound: assert property (
    wt |-> ##[1:64] !wt) else $error("wait too long");
  a_oe_cause: assert property (
    data_lines_oe |-> $past(rdReq)) else $error("drive without read");
  a_oe_release: assert property (
    !rdReq |=> !data_lines_oe) else $error("drive after read");
  a_straps_held: assert property (
    live && $past(live) |-> $stable({bigEndian, busClockHalf}))
    else $error("strap copy moved");
  a_ratio_copy: assert property (
    live |-> busClockHalf == clock_divide_strap) else $error("ratio copy");
  c_read: cover property (live && $rose(rdReq));
  c_stall: cover property (wt && refresh_busy);
  c_release: cover property (live && $fell(wt));
endmodule : ghp_port_chk
bind ghp_port ghp_port_chk u_chk (.*);

// [verification/ghp_host_model.sv]
// host bus master model: one access at a time on the port pins
`timescale 1ns/1ps
module ghp_host_model
  import ghp_pkg::*;
(
  // clock and wait sense
  input wire logic clk,
  input wire logic pol,
  // port pins
  output logic [ADDR_W-1:0] addrOut,
  output logic spaceOut,
  output logic selN,
  output logic wrLowN,
  output logic wrHighN,
  output logic rdLowN,
  output logic rdHighN,
  output logic busStatusN,
  output logic [DATA_W-1:0] dataOut,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic holdOffN
);
  // idle: strobes high, status tied high
  initial begin
    {selN, wrLowN, wrHighN, rdLowN, rdHighN} = 5'h1f;
    busStatusN = 1'b1;
    addrOut = '0;
    spaceOut = 1'b0;
    dataOut = '0;
  end
  // drive at falling edge, end only after the wait is released
  task automatic access(input logic rd, input logic [1:0] ln,
      input logic [17:0] a, input logic s, input logic [15:0] d,
      output logic [15:0] q, output logic ok);
    int n;
    logic seen;
    @(negedge clk);
    addrOut = a;
    spaceOut = s;
    selN = 1'b0;
    if (rd) begin
      {rdLowN, rdHighN} = 2'h0;
    end else begin
      dataOut = d;
      wrLowN = !ln[0];
      wrHighN = !ln[1];
    end
    for (n = 0; n < 8 && holdOffN != pol; n++) @(negedge clk);
    seen = (holdOffN == pol);
    for (n = 0; n < 100 && holdOffN == pol; n++) @(negedge clk);
    ok = seen && (holdOffN != pol);
    @(negedge clk);
    q = dataIn;
    // release; stale address and data must not look valid
    {selN, wrLowN, wrHighN, rdLowN, rdHighN} = 5'h1f;
    addrOut = ~a;
    dataOut = ~dataOut;
  endtask : access
endmodule : ghp_host_model

// [verification/ghp_tb.sv]
// testbench: port accesses checked against a behavioural memory
`timescale 1ns/1ps
module testbench;
  import ghp_pkg::*;
  // --------
  // signals
  // --------
  logic clk, rstn, endianS, polS, divS, refreshBusy;
  logic [ADDR_W-1:0] addrIn;
  logic sp, selN, wlN, whN, rlN, rhN, bsN, oe, holdN, bigE, half;
  logic [DATA_W-1:0] dIn, dOut;
  logic [15:0] mdl [int]; // word store as the lanes hold it
  logic [17:0] aq[$]; // addresses written in little endian
  int n_mismatch, comparisons;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // refresh steals the memory at random
  always @(negedge clk) refreshBusy <= ($urandom % 4 == 0);
  ghp_host_model host (.clk(clk), .pol(polS), .addrOut(addrIn),
    .spaceOut(sp), .selN(selN), .wrLowN(wlN), .wrHighN(whN),
    .rdLowN(rlN), .rdHighN(rhN), .busStatusN(bsN), .dataOut(dIn),
    .dataIn(dOut), .holdOffN(holdN));
  ghp_port dut (.clk(clk), .rstn(rstn), .endian_strap(endianS),
    .hold_polarity_strap(polS), .clock_divide_strap(divS),
    .addr_in(addrIn), .space_select(sp), .device_select_n(selN),
    .low_byte_write_n(wlN), .high_byte_write_n(whN),
    .low_byte_read_n(rlN), .high_byte_read_n(rhN), .bus_status_n(bsN),
    .data_lines_in(dIn), .data_lines_out(dOut), .data_lines_oe(oe),
    .hold_off_n(holdN), .refresh_busy(refreshBusy), .bigEndian(bigE),
    .busClockHalf(half));
  // --------
  // tasks
  // --------
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // reset with given straps, then check the latched copies
  task automatic boot(input logic e, input logic p, input logic dv);
    @(negedge clk);
    rstn = 1'b0;
    endianS = e;
    polS = p;
    divS = dv;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    chk({15'h0, e}, {15'h0, bigE});
    chk({15'h0, dv}, {15'h0, half});
    chk(16'h0, {15'h0, oe});
  endtask : boot
  // one access; big endian swaps bytes both ways
  task automatic go(input logic rd, input logic [1:0] ln,
      input logic [17:0] a, input logic s, input logic [15:0] d);
    logic [15:0] q, w;
    logic ok;
    int k;
    k = {s, a[17:1]};
    host.access(rd, ln, a, s, d, q, ok);
    chk(16'h1, {15'h0, ok});
    if (ok !== 1'b1) results();
    chk({15'h0, rd}, {15'h0, oe});
    w = endianS ? {d[7:0], d[15:8]} : d;
    if (rd) chk(endianS ? {mdl[k][7:0], mdl[k][15:8]} : mdl[k], q);
    else begin
      if (ln[0]) mdl[k][7:0] = w[7:0];
      if (ln[1]) mdl[k][15:8] = w[15:8];
    end
  endtask : go
  // --------
  // sequence
  // --------
  initial begin
    int i;
    logic [17:0] a;
    logic [15:0] d;
    {rstn, endianS, polS, divS, refreshBusy} = 5'h00;
    void'($urandom(80406));
    boot(1'b0, 1'b0, 1'b0);
    for (i = 0; i < 12; i++) begin
      a = 18'($urandom);
      d = 16'($urandom);
      aq.push_back(a);
      go(1'b0, 2'h3, a, i[0], d);
      go(1'b0, 2'h3, a, ~i[0], d ^ 16'h00ff);
      go(1'b0, i[1] ? 2'h2 : 2'h1, a, i[0], ~d);
      go(1'b1, 2'h0, a, i[0], 16'h0);
      go(1'b1, 2'h0, a, ~i[0], 16'h0);
    end
    $display("test lanes and spaces done");
    boot(1'b1, 1'b1, 1'b0);
    foreach (aq[j]) go(1'b1, 2'h0, aq[j], 1'b0, 16'h0);
    for (i = 0; i < 8; i++) begin
      a = 18'($urandom);
      go(1'b0, 2'h3, a, i[0], 16'($urandom));
      go(1'b1, 2'h0, a, i[0], 16'h0);
    end
    endianS = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'h1, {15'h0, bigE});
    $display("test big endian and polarity done");
    boot(1'b0, 1'b0, 1'b1);
    for (i = 0; i < 6; i++) begin
      a = 18'($urandom);
      d = 16'($urandom);
      go(1'b0, 2'h3, a, i[1], d);
      go(1'b0, i[0] ? 2'h1 : 2'h2, a, i[1], ~d);
      go(1'b1, 2'h0, a, i[1], 16'h0);
    end
    $display("test half rate bus clock done");
    results();
  end
endmodule : testbench
